// ===== src/pwr_mode_cfg.svh
// register offsets, field positions, reset values and timing counts
`ifndef PWR_MODE_CFG_SVH
`define PWR_MODE_CFG_SVH
`define OFS_PROT 2'h0
`define OFS_CTRL 2'h1
`define OFS_SUB 2'h2
`define OFS_STAT 2'h3
`define OFS_IRQ_STAT 3'h4
`define OFS_IRQ_MASK 3'h5
`define PROT_AVLP 5
`define PROT_ALLOW_LEAKAGE_STOP 3
`define PROT_ALLOW_DEEPEST_STOPS 1
`define PROT_RST 8'h00
`define CTRL_RST 8'h00
`define SUB_RST 8'h00
`define CTRL_WMASK 8'hE7
`define CTRL_RMASK 8'hEF
`define SUB_WMASK 8'h17
`define SUB_RAM2 4
`define STOP_KIND_SELECT_NORMAL 3'h0
`define STOP_KIND_SELECT_VERY_LOW_POWER_STOP 3'h2
`define STOP_KIND_SELECT_LLS 3'h3
`define STOP_KIND_SELECT_VLLS 3'h4
`define RUN_KIND_SELECT_VERY_LOW_POWER_RUN 2'h2
`define STAT_RUN 8'h01
`define STAT_STOP 8'h02
`define STAT_VERY_LOW_POWER_RUN 8'h04
`define STAT_VERY_LOW_POWER_WAIT 8'h08
`define STAT_VERY_LOW_POWER_STOP 8'h10
`define STAT_LLS 8'h20
`define STAT_VLLS 8'h40
`define STAT_WAIT 8'h80
`define ENTRY_NS 160
`define ENTRY_CYC (((`ENTRY_NS) + 39) / 40)
`endif

// ===== src/pwr_mode_pkg.sv
// types shared by the power mode controller
package pwr_mode_pkg;
   typedef enum logic [5:0]
   {
      ST_RUN = 6'b00_0001,
      ST_WAIT = 6'b00_0010,
      ST_ENTRY = 6'b00_0100,
      ST_STOP = 6'b00_1000,
      ST_EMUL = 6'b01_0000,
      ST_VERY_LOW_POWER_WAIT = 6'b10_0000
   } mode_state_t;
   typedef logic [7:0] byte_t;
endpackage

// ===== src/entry_timer.sv
// countdown timer pacing the stop entry sequence
`timescale 1ns/1ps
`include "pwr_mode_cfg.svh"
module entry_timer
(
   input wire logic i_mclk, // system clock
   input wire logic i_rstn, // async reset, active low
   input wire logic i_start, // load the count
   input wire logic i_clear, // abandon the count
   output logic o_done // one-cycle pulse at expiry
);
   typedef struct packed
   {
      logic [7:0] cnt;
      logic busy;
      logic done;
   } tmr_t;
   tmr_t s_q;
   tmr_t s_d;
   always_comb
   begin
      s_d = s_q;
      s_d.done = 1'b0;
      if (i_clear)
      begin
         s_d.busy = 1'b0;
      end
      else if (i_start)
      begin
         s_d.busy = 1'b1;
         s_d.cnt = 8'(`ENTRY_CYC - 1);
      end
      else if (s_q.busy)
      begin
         if (s_q.cnt == 8'h00)
         begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
         end
         else
         begin
            s_d.cnt = s_q.cnt - 8'h01;
         end
      end
   end
   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end
   assign o_done = s_q.done;
endmodule

// ===== src/system_power_mode_controller.sv
// system power mode controller: protection, mode select, stop entry
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "pwr_mode_cfg.svh"
// Functional notes
// [R1]: mode protection takes only the first write after each reset.
// [R2]: the three-bit stop kind select picks the stop entered on deep sleep.
// [R3]: codes 000 stop, 010 very_low_power_stop, 011 lls, 100 vlls; others reserved.
// [R4]: a stop kind write is dropped unless its protection bit is set.
// [R5]: a successful protection write clears the stop kind select.
// [R6]: under vlls the submode field picks 001, 010 or 011; others reserved.
// [R7]: interrupt or reset during stop entry aborts to run and sets a flag; here only a pending interrupt sets the flag, reset clears it.
// [R8]: the status register reports the current power mode.
// [R9]: the ram part two bit keeps ram partition 2 powered in deepest_stop_two.
// [R10]: one allow bit governs all very low leakage submodes.
// [R11]: software sets protection, then stop kind, then submode for vlls.
// [R12]: software writes protection at init to allow only needed modes.
// [R13]: debug stays available in run, wait, very_low_power_run and very_low_power_wait.
// [R14]: with a debugger, stop or very_low_power_stop becomes an emulated stop.
// [R15]: very low power run and wait are supported.
// [R16]: status reads 04 in very low power run.
// [R17]: control bit 4 reads zero and ignores writes; control resets to 0.
module system_power_mode_controller
(
   input wire logic i_mclk, // 25 MHz system clock
   input wire logic i_rstn, // async reset, active low
   input wire logic [2:0] i_addr, // register index
   input wire pwr_mode_pkg::byte_t i_wdata, // write data
   input wire logic i_wr, // write strobe
   input wire logic i_rd, // read strobe
   output pwr_mode_pkg::byte_t o_rdata, // read data, cycle after i_rd
   input wire logic i_sleep, // core sleep request pulse
   input wire logic i_deep_sleep_request_bit, // core deep sleep bit
   input wire logic i_irq_pending, // any pending core interrupt
   input wire logic i_wake, // wakeup from stop
   input wire logic i_dbg_attached, // debugger present
   output logic o_stop_active, // device in a real stop mode
   output logic [2:0] o_stop_kind, // stop kind being applied
   output logic [2:0] o_submode, // leakage submode being applied
   output logic o_ram_part_two_power, // keep ram partition 2 powered
   output logic o_dbg_avail, // debug operation allowed
   output logic o_irq // level interrupt
);
   import pwr_mode_pkg::*;

   typedef struct packed
   {
      mode_state_t st;
      byte_t prot;
      byte_t ctrl;
      byte_t sub;
      logic prot_done;
      byte_t rdata;
      logic [1:0] ev;
      logic [1:0] mask;
   } ctl_t;

   ctl_t s_q;
   ctl_t s_d;
   logic entry_done;
   logic start_entry;
   logic abort;
   logic [2:0] new_stop_kind_select;
   logic stop_kind_select_ok;
   logic kind_emul;
   byte_t stat;

   entry_timer u_timer
   (
      .i_mclk(i_mclk),
      .i_rstn(i_rstn),
      .i_start(start_entry),
      .i_clear(abort),
      .o_done(entry_done)
   );

   // protection check for a proposed stop kind
   always_comb
   begin
      new_stop_kind_select = i_wdata[2:0];
      case (new_stop_kind_select) // [R3]
         `STOP_KIND_SELECT_NORMAL: stop_kind_select_ok = 1'b1;
         `STOP_KIND_SELECT_VERY_LOW_POWER_STOP: stop_kind_select_ok = s_q.prot[`PROT_AVLP]; // [R4]
         `STOP_KIND_SELECT_LLS: stop_kind_select_ok = s_q.prot[`PROT_ALLOW_LEAKAGE_STOP]; // [R4]
         `STOP_KIND_SELECT_VLLS: stop_kind_select_ok = s_q.prot[`PROT_ALLOW_DEEPEST_STOPS]; // [R4] [R10]
         default: stop_kind_select_ok = 1'b0;
      endcase
   end

   // debugger turns stop and very_low_power_stop into an emulated stop
   assign kind_emul = i_dbg_attached &&
      (s_q.ctrl[2:0] == `STOP_KIND_SELECT_NORMAL || s_q.ctrl[2:0] == `STOP_KIND_SELECT_VERY_LOW_POWER_STOP);
   assign start_entry = i_sleep && i_deep_sleep_request_bit &&
      (s_q.st == ST_RUN) && !kind_emul; // [R2]
   assign abort = (s_q.st == ST_ENTRY) && i_irq_pending; // [R7]

   always_comb
   begin
      case (s_q.st) // [R8] [R16]
         ST_RUN: stat = (s_q.ctrl[6:5] == `RUN_KIND_SELECT_VERY_LOW_POWER_RUN) ? `STAT_VERY_LOW_POWER_RUN
            : `STAT_RUN;
         ST_WAIT: stat = `STAT_WAIT;
         ST_VERY_LOW_POWER_WAIT: stat = `STAT_VERY_LOW_POWER_WAIT;
         ST_EMUL: stat = `STAT_STOP;
         ST_STOP:
         begin
            case (s_q.ctrl[2:0])
               `STOP_KIND_SELECT_VERY_LOW_POWER_STOP: stat = `STAT_VERY_LOW_POWER_STOP;
               `STOP_KIND_SELECT_LLS: stat = `STAT_LLS;
               `STOP_KIND_SELECT_VLLS: stat = `STAT_VLLS;
               default: stat = `STAT_STOP;
            endcase
         end
         default: stat = `STAT_RUN;
      endcase
   end

   always_comb
   begin
      s_d = s_q;
      s_d.rdata = 8'h00;
      if (i_wr)
      begin
         case (i_addr)
            {1'b0, `OFS_PROT}:
            begin
               if (!s_q.prot_done) // [R1]
               begin
                  s_d.prot = i_wdata;
                  s_d.prot_done = 1'b1;
                  s_d.ctrl[2:0] = `STOP_KIND_SELECT_NORMAL; // [R5]
               end
            end
            {1'b0, `OFS_CTRL}:
            begin
               s_d.ctrl[7:5] = i_wdata[7:5];
               if (stop_kind_select_ok)
               begin
                  s_d.ctrl[2:0] = new_stop_kind_select; // [R4]
               end
            end
            {1'b0, `OFS_SUB}: s_d.sub = i_wdata & `SUB_WMASK; // [R6] [R9]
            `OFS_IRQ_MASK: s_d.mask = i_wdata[1:0];
            default: ;
         endcase
      end
      if (i_rd)
      begin
         case (i_addr)
            {1'b0, `OFS_PROT}: s_d.rdata = s_q.prot;
            // aborted flag is read-only but must stay visible
            {1'b0, `OFS_CTRL}: s_d.rdata = s_q.ctrl & `CTRL_RMASK; // [R17]
            {1'b0, `OFS_SUB}: s_d.rdata = s_q.sub;
            {1'b0, `OFS_STAT}: s_d.rdata = stat;
            `OFS_IRQ_STAT:
            begin
               s_d.rdata = {6'h00, s_q.ev};
               s_d.ev = 2'b00;
            end
            `OFS_IRQ_MASK: s_d.rdata = {6'h00, s_q.mask};
            default: s_d.rdata = 8'h00;
         endcase
      end
      case (s_q.st)
         ST_RUN:
         begin
            if (i_sleep && i_deep_sleep_request_bit)
            begin
               s_d.st = kind_emul ? ST_EMUL : ST_ENTRY; // [R14]
               s_d.ctrl[3] = 1'b0;
            end
            else if (i_sleep)
            begin
               s_d.st = (s_q.ctrl[6:5] == `RUN_KIND_SELECT_VERY_LOW_POWER_RUN) ? ST_VERY_LOW_POWER_WAIT
                  : ST_WAIT; // [R15]
            end
         end
         ST_ENTRY:
         begin
            if (abort)
            begin
               s_d.st = ST_RUN;
               s_d.ctrl[3] = 1'b1; // [R7]
               s_d.ev[0] = 1'b1;
            end
            else if (entry_done)
            begin
               s_d.st = ST_STOP;
            end
         end
         ST_STOP, ST_EMUL, ST_WAIT, ST_VERY_LOW_POWER_WAIT:
         begin
            if (i_wake)
            begin
               s_d.st = ST_RUN;
               s_d.ev[1] = 1'b1;
            end
         end
         default: s_d.st = ST_RUN;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         s_q.st <= ST_RUN;
         s_q.prot <= `PROT_RST;
         s_q.ctrl <= `CTRL_RST; // [R17]
         s_q.sub <= `SUB_RST;
         s_q.prot_done <= 1'b0;
         s_q.rdata <= 8'h00;
         s_q.ev <= 2'b00;
         s_q.mask <= 2'b00;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign o_rdata = s_q.rdata;
   assign o_stop_active = (s_q.st == ST_STOP);
   assign o_stop_kind = s_q.ctrl[2:0];
   assign o_submode = s_q.sub[2:0];
   assign o_ram_part_two_power = s_q.sub[`SUB_RAM2]; // [R9]
   assign o_dbg_avail = (s_q.st == ST_RUN) || (s_q.st == ST_WAIT) ||
      (s_q.st == ST_VERY_LOW_POWER_WAIT); // [R13]
   assign o_irq = |(s_q.ev & s_q.mask);

   AST_PROT_ONCE: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      s_q.prot_done |=> $stable(s_q.prot)) // [R1]
      else $error("protection changed after first write");
   AST_STOP_KIND_SELECT_BLOCK: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (i_wr && i_addr == 3'h1 && !stop_kind_select_ok && !s_q.prot_done == 1'b0)
      |=> o_stop_kind == $past(o_stop_kind)) // [R4]
      else $error("blocked stop kind write took effect");
   AST_PROT_CLR: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (i_wr && i_addr == 3'h0 && !s_q.prot_done) |=> o_stop_kind == 3'h0)
      // [R5]
      else $error("stop kind not cleared by protection write");
   AST_ABORT: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      abort |=> s_q.st == ST_RUN && s_q.ctrl[3]) // [R7]
      else $error("abort did not return to run with flag");
   AST_VERY_LOW_POWER_RUN_STAT: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (i_rd && i_addr == 3'h3 && s_q.st == ST_RUN && s_q.ctrl[6:5] == 2'h2)
      |=> o_rdata == 8'h04) // [R16] [R8]
      else $error("status not 04 in very_low_power_run");
   AST_BIT4: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (i_rd && i_addr == 3'h1) |=> !o_rdata[4]) // [R17]
      else $error("control bit 4 read as one");
   AST_EMUL: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (i_sleep && i_deep_sleep_request_bit && s_q.st == ST_RUN && kind_emul)
      |=> s_q.st == ST_EMUL && !o_stop_active) // [R14]
      else $error("debugger stop not emulated");
   AST_ENTRY_TIME: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (start_entry && !i_irq_pending) ##1 (!i_irq_pending)[*5]
      |=> o_stop_active) // [R2]
      else $error("stop not reached after entry time");
   AST_DBG: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      o_stop_active |-> !o_dbg_avail) // [R13]
      else $error("debug available in real stop");
   AST_RAM2: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      o_ram_part_two_power == s_q.sub[4]) // [R9]
      else $error("ram power output mismatch");
   COV_STOP: cover property (@(posedge i_mclk) o_stop_active);
   COV_ABORT: cover property (@(posedge i_mclk) abort);
   COV_EMUL: cover property (@(posedge i_mclk) s_q.st == ST_EMUL);
   COV_VERY_LOW_POWER_WAIT: cover property (@(posedge i_mclk) s_q.st == ST_VERY_LOW_POWER_WAIT);
endmodule

// ===== verification/core_partner.sv
// core and debugger model driving the sleep, wake and debug lines
`timescale 1ns/1ps
module core_partner
(
   input wire logic i_mclk, // system clock
   output logic o_sleep = 1'b0, // sleep request pulse
   output logic o_deep = 1'b0, // deep sleep bit, valid with the pulse
   output logic o_irq_pending = 1'b0, // pending core interrupt
   output logic o_wake = 1'b0, // wakeup pulse
   output logic o_dbg_attached = 1'b0 // debugger present
);
   task automatic sleep_req(input logic deep);
      @(posedge i_mclk);
      o_sleep <= 1'b1;
      o_deep <= deep;
      @(posedge i_mclk);
      o_sleep <= 1'b0;
      // not held once the pulse ends, so no stale level can be relied on
      o_deep <= ~deep;
   endtask
   task automatic wake_up();
      @(posedge i_mclk);
      o_wake <= 1'b1;
      @(posedge i_mclk);
      o_wake <= 1'b0;
   endtask
endmodule

// ===== verification/testbench.sv
// self-checking bench for the system power mode controller
`timescale 1ns/1ps
`include "pwr_mode_cfg.svh"
module testbench;
   import pwr_mode_pkg::*;
   logic i_mclk = 1'b0;
   logic i_rstn = 1'b0;
   logic [2:0] i_addr = 3'h0;
   byte_t i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   byte_t o_rdata;
   logic slp, deep, irqp, wake, dbg;
   logic o_stop_active, o_ram_part_two_power, o_dbg_avail, o_irq;
   logic [2:0] o_stop_kind, o_submode;
   int n_fail = 0;
   int num_checks = 0;
   int cycles = 0;
   int m[0:5] = '{0, 0, 0, 1, 0, 0};
   bit pw = 0;
   int k, j;
   always #20 i_mclk = ~i_mclk;
   system_power_mode_controller system_power_mode_controller_inst (
      .i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_sleep(slp), .i_deep_sleep_request_bit(deep),
      .i_irq_pending(irqp), .i_wake(wake), .i_dbg_attached(dbg),
      .o_stop_active(o_stop_active), .o_stop_kind(o_stop_kind),
      .o_submode(o_submode), .o_ram_part_two_power(o_ram_part_two_power),
      .o_dbg_avail(o_dbg_avail), .o_irq(o_irq));
   core_partner core_partner_inst (
      .i_mclk(i_mclk), .o_sleep(slp), .o_deep(deep),
      .o_irq_pending(irqp), .o_wake(wake), .o_dbg_attached(dbg));
   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [2:0] a, input byte_t d);
      bit ok;
      @(posedge i_mclk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
      ok = d[2:0] == 0 || (d[2:0] == 2 && m[0][5]) ||
           (d[2:0] == 3 && m[0][3]) || (d[2:0] == 4 && m[0][1]);
      if (a == 0 && !pw)
      begin
         m[0] = d;
         pw = 1;
         m[1] = m[1] & 'hF8;
      end
      if (a == 1)
         m[1] = (d & 'hE0) | (m[1] & 8) | (ok ? d[2:0] : m[1] & 7);
      if (a == 2)
         m[2] = d & 'h17;
      if (a == 5)
         m[5] = d;
   endtask
   task automatic rd(input logic [2:0] a, input int exp);
      @(posedge i_mclk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 check("rdata", o_rdata, exp[7:0]);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // a hang ends the run as a mismatch
   always @(posedge i_mclk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         n_fail++;
         complete_run();
      end
   end
   initial
   begin
      void'($urandom(79458));
      repeat (8) @(posedge i_mclk);
      i_rstn <= 1'b1;
      rd(0, 0);
      rd(1, 0);
      rd(3, `STAT_RUN);
      $display("test reset done");
      wr(1, 8'h02);
      check("kind", {5'h00, o_stop_kind}, 8'h00);
      wr(0, 8'h2A);
      wr(0, 8'h00);
      rd(0, m[0]);
      $display("test protection done");
      for (k = 0; k < 8; k++)
      begin
         wr(1, 8'h10 | k[7:0]);
         rd(1, m[1]);
         check("kind", {5'h00, o_stop_kind}, m[1][7:0] & 8'h07);
      end
      $display("test stop codes done");
      repeat (4)
      begin
         wr(2, byte_t'($urandom));
         rd(2, m[2]);
         check("sub", {5'h00, o_submode}, m[2][7:0] & 8'h07);
         check("ram", {7'h00, o_ram_part_two_power}, m[2][11:4]);
      end
      $display("test submode done");
      for (k = 1; k < 4; k++)
      begin
         wr(2, 8'h10 | k[7:0]);
         core_partner_inst.sleep_req(1'b1);
         m[1] = m[1] & 'hF7;
         for (j = 0; j < 20 && o_stop_active !== 1'b1; j++)
            @(posedge i_mclk);
         check("stop", {7'h00, o_stop_active}, 8'h01);
         rd(3, `STAT_VLLS);
         core_partner_inst.wake_up();
         m[4] = m[4] | 2;
         rd(3, `STAT_RUN);
      end
      $display("test deep stops done");
      wr(5, 8'h01);
      core_partner_inst.o_irq_pending <= 1'b1;
      core_partner_inst.sleep_req(1'b1);
      repeat (10) @(posedge i_mclk);
      m[1] = m[1] | 8;
      check("stop", {7'h00, o_stop_active}, 8'h00);
      rd(1, m[1]);
      rd(3, `STAT_RUN);
      check("irq", {7'h00, o_irq}, 8'h01);
      rd(4, m[4] | 1);
      check("irq", {7'h00, o_irq}, 8'h00);
      core_partner_inst.o_irq_pending <= 1'b0;
      $display("test abort done");
      wr(1, 8'h40);
      rd(3, `STAT_VERY_LOW_POWER_RUN);
      check("dbg", {7'h00, o_dbg_avail}, 8'h01);
      wr(1, 8'h00);
      rd(3, `STAT_RUN);
      core_partner_inst.sleep_req(1'b0);
      repeat (3) @(posedge i_mclk);
      rd(3, `STAT_WAIT);
      check("dbg", {7'h00, o_dbg_avail}, 8'h01);
      core_partner_inst.wake_up();
      $display("test run kinds done");
      core_partner_inst.o_dbg_attached <= 1'b1;
      core_partner_inst.sleep_req(1'b1);
      repeat (10) @(posedge i_mclk);
      check("stop", {7'h00, o_stop_active}, 8'h00);
      rd(3, `STAT_STOP);
      core_partner_inst.wake_up();
      rd(3, `STAT_RUN);
      $display("test debug stop done");
      complete_run();
   end
endmodule
